// ===== expander_device.sv
// Port expander device end: serial shifter on the link clock, pin control on clk_sys
`timescale 1ns/1ps
module expander_device
(
    input wire logic clk_sys,
    input wire logic rst,
    expander_link_if.dev link,
    input wire logic [23:0] padIn,
    output logic [23:0] padOut,
    output logic [23:0] padOe,
    output logic dataMode
);
    // ----------------------------------------
    // Link clock domain
    // ----------------------------------------
    logic started_reg;
    logic [4:0] bitCnt_reg;
    logic [4:0] bitCnt_next;
    logic fullSeen_reg;
    logic fullSeen_next;
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic dout_reg;
    logic dout_next;
    logic firstRise;
    logic bitWrap;

    // ----------------------------------------
    // System clock domain
    // ----------------------------------------
    logic [26:0] syncIn;
    logic [26:0] syncOut;
    logic startedS;
    logic resetNS;
    logic csNS;
    logic [23:0] padS;
    logic csPrev_reg;
    logic sawEdges_reg;
    logic sawEdges_next;
    logic [15:0] holdCnt_reg;
    logic [15:0] holdCnt_next;
    logic [23:0] dir_reg;
    logic [23:0] dir_next;
    logic [23:0] level_reg;
    logic [23:0] level_next;
    logic [23:0] pinCap_reg;
    logic [23:0] pinCap_next;
    logic [23:0] padOut_reg;
    logic [23:0] padOe_reg;
    logic [23:0] inputOpen;
    expander_pkg::dev_state_t state_reg;
    expander_pkg::dev_state_t state_next;
    logic devReset;
    logic csRise;
    logic frameOk;
    logic holdDone;

    // ----------------------------------------
    // Shifter on the link clock
    // ----------------------------------------
    // Counters are not cleared by select high so the system side can still read them
    // after the frame; the first edge of a new frame restarts them instead.
    assign firstRise = ~started_reg;
    assign bitWrap = (bitCnt_reg == expander_pkg::BIT_LAST);
    // Select high holds everything, so stray clocks cannot spoil a word not yet taken
    assign bitCnt_next = link.csN ? bitCnt_reg
                       : (firstRise ? 5'h01 : (bitWrap ? 5'h00 : bitCnt_reg + 5'h01));
    assign fullSeen_next = link.csN ? fullSeen_reg
                         : (firstRise ? 1'b0 : (fullSeen_reg | bitWrap));
    // Pin 0 left on the first fall, pins 1..23 captured here, input bits enter at the top
    assign shift_next = link.csN ? shift_reg
                      : (firstRise ? {link.din, pinCap_reg[23:1]}
                                   : {link.din, shift_reg[23:1]});
    assign dout_next = firstRise ? pinCap_reg[0] : shift_reg[0];

    always_ff @(posedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
            started_reg <= 1'b0;
        else
            started_reg <= 1'b1;
    end

    always_ff @(posedge link.sclk)
    begin
        bitCnt_reg <= bitCnt_next;
        fullSeen_reg <= fullSeen_next;
        shift_reg <= shift_next;
    end

    // Select high forces dout high; reset implies select high
    always_ff @(negedge link.sclk or posedge link.csN)
    begin
        if (link.csN)
            dout_reg <= 1'b1;
        else
            dout_reg <= dout_next;
    end

    assign link.dout = dout_reg;

    // ----------------------------------------
    // Synchronisers into clk_sys
    // ----------------------------------------
    assign syncIn = {started_reg, link.resetN, link.csN, padIn};

    pin_sync
    #(
        .WIDTH(27),
        .INIT(27'h3ffffff)
    )
    u_sync
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .async(syncIn),
        .synced(syncOut)
    );

    assign startedS = syncOut[26];
    assign resetNS = syncOut[25];
    assign csNS = syncOut[24];
    assign padS = syncOut[23:0];

    // ----------------------------------------
    // Frame end and mode decode
    // ----------------------------------------
    assign devReset = rst | ~resetNS;
    assign csRise = csNS & ~csPrev_reg;
    // Only whole multiples of 24 bits count; any other length leaves registers as they were
    assign frameOk = sawEdges_reg & fullSeen_reg & (bitCnt_reg == 5'h00);
    assign sawEdges_next = csNS ? (sawEdges_reg & ~csRise) : (sawEdges_reg | startedS);
    assign holdDone = (holdCnt_reg == 16'(expander_pkg::SELECT_LOW_HOLD_CYC - 1));
    assign holdCnt_next = (csNS || sawEdges_reg || startedS) ? 16'h0000
                        : (holdDone ? holdCnt_reg : holdCnt_reg + 16'h0001);

    always_comb
    begin
        state_next = state_reg;
        dir_next = dir_reg;
        level_next = level_reg;
        case (state_reg)
            expander_pkg::DEV_CONFIG:
            begin
                if (holdDone && !csNS && !startedS)
                begin
                    dir_next = expander_pkg::DIR_RESET;
                    state_next = expander_pkg::DEV_DATA;
                end
                else if (csRise && frameOk)
                begin
                    dir_next = shift_reg;
                    state_next = expander_pkg::DEV_DATA;
                end
            end
            expander_pkg::DEV_DATA:
            begin
                if (csRise && frameOk)
                    level_next = shift_reg;
            end
            default:
                state_next = expander_pkg::DEV_CONFIG;
        endcase
    end

    // Pin samples freeze while select is low so the link side reads a steady word
    assign pinCap_next = csNS ? (padS | ~inputOpen) : pinCap_reg;

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    assign inputOpen = ~dir_reg & level_reg;

    always_ff @(posedge clk_sys)
    begin
        if (devReset)
        begin
            state_reg <= expander_pkg::DEV_CONFIG;
            dir_reg <= expander_pkg::DIR_RESET;
            level_reg <= expander_pkg::LEVEL_RESET;
            csPrev_reg <= 1'b1;
            sawEdges_reg <= 1'b0;
            holdCnt_reg <= 16'h0000;
            pinCap_reg <= expander_pkg::LEVEL_RESET;
        end
        else
        begin
            state_reg <= state_next;
            dir_reg <= dir_next;
            level_reg <= level_next;
            csPrev_reg <= csNS;
            sawEdges_reg <= sawEdges_next;
            holdCnt_reg <= holdCnt_next;
            pinCap_reg <= pinCap_next;
        end
    end

    // Open-drain drives only low; push-pull drives either level
    always_ff @(posedge clk_sys)
    begin
        if (devReset)
        begin
            padOut_reg <= 24'h000000;
            padOe_reg <= 24'h000000;
        end
        else
        begin
            padOut_reg <= dir_reg & level_reg;
            padOe_reg <= dir_reg | ~level_reg;
        end
    end

    assign padOut = padOut_reg;
    assign padOe = padOe_reg;
    assign dataMode = state_reg;
endmodule : expander_device

// ===== expander_pkg.sv
// Shared constants and types for the serial port expander link
package expander_pkg;
    // ----------------------------------------
    // Port geometry and reset values
    // ----------------------------------------
    localparam int PORT_BITS = 24;
    localparam logic [23:0] DIR_RESET = 24'h000000;
    localparam logic [23:0] LEVEL_RESET = 24'hffffff;
    localparam logic [4:0] BIT_LAST = 5'h17;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int SYS_CLK_MHZ = 40;
    localparam int SELECT_LOW_HOLD_TIME_NS = 1000;
    localparam int SELECT_LOW_HOLD_CYC = (SELECT_LOW_HOLD_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int HOST_HALF_DIV = 4;
    // ----------------------------------------
    // State encodings
    // ----------------------------------------
    typedef enum logic {
        DEV_CONFIG = 1'b0,
        DEV_DATA = 1'b1
    } dev_state_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LEAD = 3'b001,
        H_LOW = 3'b010,
        H_HIGH = 3'b011,
        H_TAIL = 3'b100,
        H_HOLD = 3'b101
    } host_state_t;
endpackage : expander_pkg

// ===== expander_link_if.sv
// Serial link between the host controller and the port expander
`timescale 1ns/1ps
interface expander_link_if;
    logic sclk;
    logic csN;
    logic din;
    logic dout;
    logic resetN;
    modport host
    (
        output sclk,
        output csN,
        output din,
        output resetN,
        input dout
    );
    modport dev
    (
        input sclk,
        input csN,
        input din,
        input resetN,
        output dout
    );
endinterface : expander_link_if

// ===== pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] synced_reg;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] synced_next;

    // A bit only moves once the second and third stage agree
    assign agree = ~(stage2_reg ^ stage3_reg);
    assign synced_next = (agree & stage3_reg) | (~agree & synced_reg);
    assign synced = synced_reg;

    always_ff @(posedge clk_sys)
    begin
        stage1_reg <= async;
        stage2_reg <= stage1_reg;
        stage3_reg <= stage2_reg;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            synced_reg <= INIT;
        else
            synced_reg <= synced_next;
    end
endmodule : pin_sync

// ===== expander_host.sv
// Host end: makes the link clock, reset and select, shifts whole frames
`timescale 1ns/1ps
module expander_host
#(
    parameter int CHAIN = 1,
    parameter int HALF_DIV = expander_pkg::HOST_HALF_DIV,
    parameter int HOLD_CYC = expander_pkg::SELECT_LOW_HOLD_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst,
    expander_link_if.host link,
    input wire logic resetReq,
    input wire logic mode0Req,
    input wire logic frameReq,
    input wire logic [24*CHAIN-1:0] txWord,
    output logic [24*CHAIN-1:0] rxWord,
    output logic busy,
    output logic frameDone
);
    localparam int FRAME_BITS = 24 * CHAIN;

    expander_pkg::host_state_t state_reg;
    expander_pkg::host_state_t state_next;
    logic [15:0] divCnt_reg;
    logic [15:0] bitIdx_reg;
    logic [FRAME_BITS-1:0] tx_reg;
    logic [FRAME_BITS-1:0] rx_reg;
    logic sclk_reg;
    logic csN_reg;
    logic din_reg;
    logic resetN_reg;
    logic busy_reg;
    logic done_reg;
    logic doutS;
    logic divEnd;
    logic holdEnd;
    logic lastBit;
    logic start;

    // ----------------------------------------
    // Returning data synchroniser
    // ----------------------------------------
    pin_sync
    #(
        .WIDTH(1),
        .INIT(1'b1)
    )
    u_dout_sync
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .async(link.dout),
        .synced(doutS)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Half period must cover the synchroniser lag, so keep HALF_DIV at four or more
    assign divEnd = (divCnt_reg == 16'(HALF_DIV - 1));
    assign holdEnd = (divCnt_reg == 16'(HOLD_CYC - 1));
    assign lastBit = (bitIdx_reg == 16'(FRAME_BITS - 1));
    assign start = resetN_reg && !resetReq;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            expander_pkg::H_IDLE:
                if (start && mode0Req)
                    state_next = expander_pkg::H_HOLD;
                else if (start && frameReq)
                    state_next = expander_pkg::H_LEAD;
            expander_pkg::H_LEAD:
                if (divEnd)
                    state_next = expander_pkg::H_LOW;
            expander_pkg::H_LOW:
                if (divEnd)
                    state_next = expander_pkg::H_HIGH;
            expander_pkg::H_HIGH:
                if (divEnd)
                    state_next = lastBit ? expander_pkg::H_TAIL : expander_pkg::H_LOW;
            expander_pkg::H_HOLD:
                if (holdEnd)
                    state_next = expander_pkg::H_TAIL;
            expander_pkg::H_TAIL:
                if (divEnd)
                    state_next = expander_pkg::H_IDLE;
            default:
                state_next = expander_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= expander_pkg::H_IDLE;
            divCnt_reg <= 16'h0000;
            bitIdx_reg <= 16'h0000;
            tx_reg <= '0;
            rx_reg <= '0;
            sclk_reg <= 1'b1;
            csN_reg <= 1'b1;
            din_reg <= 1'b1;
            resetN_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            divCnt_reg <= (state_next != state_reg) ? 16'h0000 : divCnt_reg + 16'h0001;
            resetN_reg <= ~resetReq;
            busy_reg <= (state_next != expander_pkg::H_IDLE);
            done_reg <= (state_reg == expander_pkg::H_TAIL) && divEnd;
            csN_reg <= (state_next == expander_pkg::H_IDLE) || (state_next == expander_pkg::H_TAIL);
            sclk_reg <= (state_next != expander_pkg::H_LOW);
            if (state_reg == expander_pkg::H_IDLE && start && frameReq)
            begin
                tx_reg <= txWord;
                bitIdx_reg <= 16'h0000;
            end
            // Falling edge: next bit out, pin 0 first
            if (state_next == expander_pkg::H_LOW && state_reg != expander_pkg::H_LOW)
            begin
                din_reg <= tx_reg[0];
                tx_reg <= {1'b1, tx_reg[FRAME_BITS-1:1]};
            end
            // End of the high half: device data has settled through the synchroniser
            if (state_reg == expander_pkg::H_HIGH && divEnd)
            begin
                rx_reg <= {doutS, rx_reg[FRAME_BITS-1:1]};
                bitIdx_reg <= bitIdx_reg + 16'h0001;
            end
        end
    end

    assign link.sclk = sclk_reg;
    assign link.csN = csN_reg;
    assign link.din = din_reg;
    assign link.resetN = resetN_reg;
    assign rxWord = rx_reg;
    assign busy = busy_reg;
    assign frameDone = done_reg;
endmodule : expander_host

// ===== expander_link_props.sv
// Link protocol checker for the serial port expander
`timescale 1ns/1ps
module expander_link_props
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    input wire logic dout,
    input wire logic resetN
);
    // ----------------------------------------
    // Frame counters
    // ----------------------------------------
    logic sclkPrev_reg;
    logic [5:0] riseCnt_reg;
    logic [5:0] riseCnt_next;
    logic [6:0] lowCnt_reg;
    logic [6:0] lowCnt_next;
    wire logic sclkRise;
    assign sclkRise = sclk & ~sclkPrev_reg;
    assign riseCnt_next = csN ? 6'h00 : riseCnt_reg + {5'h00, sclkRise};
    // Saturates so a long mode-0 hold cannot wrap
    assign lowCnt_next = csN ? 7'h00 : (lowCnt_reg == 7'h7f ? lowCnt_reg : lowCnt_reg + 7'h01);
    always_ff @(posedge clk_sys)
    begin
        sclkPrev_reg <= sclk;
        riseCnt_reg <= riseCnt_next;
        lowCnt_reg <= lowCnt_next;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence leadHigh;
        sclk [*4];
    endsequence
    sequence lowHalf;
        (!sclk) [*4] ##1 sclk;
    endsequence
    dout_reset_high_a: assert property (!resetN |-> dout)
        else $error("dout not high in reset");
    dout_idle_high_a: assert property (csN && $past(csN) |-> dout)
        else $error("dout not high while unselected");
    select_after_reset_a: assert property (!resetN |-> csN)
        else $error("select low during reset");
    select_lead_a: assert property ($fell(csN) |-> leadHigh)
        else $error("clock fell too soon after select");
    low_half_a: assert property ($fell(sclk) |-> lowHalf)
        else $error("clock low half wrong length");
    din_steady_a: assert property (!csN && !$past(csN) && sclk && $past(sclk) |-> $stable(din))
        else $error("din moved while clock high");
    frame_end_a: assert property ($rose(csN) |-> $past(sclk) && sclk)
        else $error("select rose during clock low");
    frame_length_a: assert property ($rose(csN) |-> riseCnt_reg == 6'h18 || riseCnt_reg == 6'h00)
        else $error("frame not a whole word");
    mode0_hold_a: assert property ($rose(csN) && riseCnt_reg == 6'h00
        |-> lowCnt_reg >= 7'(expander_pkg::SELECT_LOW_HOLD_CYC))
        else $error("mode 0 hold too short");
    select_gap_a: assert property ($rose(csN) |-> csN [*8])
        else $error("select high gap too short");
endmodule : expander_link_props

// ===== test_serial_io_expander_24bit.sv
// Bench: host and device joined, plus a bench-driven device for bad frames
`timescale 1ns/1ps
module test_serial_io_expander_24bit;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic resetReq = 1'b0;
    logic mode0Req = 1'b0;
    logic frameReq = 1'b0;
    logic [23:0] txWord = 24'h000000;
    logic [23:0] padIn = 24'h000000;
    logic [23:0] rxWord;
    logic [23:0] padOut;
    logic [23:0] padOe;
    logic [23:0] padOutB;
    logic [23:0] padOeB;
    logic busy;
    logic frameDone;
    logic dataMode;
    logic dataModeB;
    logic [23:0] dirExp = expander_pkg::DIR_RESET;
    logic [23:0] lvlExp = expander_pkg::LEVEL_RESET;
    int bad_count = 0;
    int num_checks = 0;
    expander_link_if link ();
    expander_link_if linkB ();
    always #12.5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Ends under test
    // ----------------------------------------
    // Hold stretched past the device threshold to cover synchroniser lag
    expander_host #(.HOLD_CYC(expander_pkg::SELECT_LOW_HOLD_CYC + 8)) u_expander_host
    (.clk_sys(clk_sys), .rst(rst), .link(link), .resetReq(resetReq), .mode0Req(mode0Req), .frameReq(frameReq),
     .txWord(txWord), .rxWord(rxWord), .busy(busy), .frameDone(frameDone));
    expander_device u_expander_device
    (.clk_sys(clk_sys), .rst(rst), .link(link), .padIn(padIn), .padOut(padOut), .padOe(padOe),
     .dataMode(dataMode));
    expander_device u_expander_device_b
    (.clk_sys(clk_sys), .rst(rst), .link(linkB), .padIn(padIn), .padOut(padOutB), .padOe(padOeB),
     .dataMode(dataModeB));
    expander_link_props u_props
    (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk), .csN(link.csN), .din(link.din), .dout(link.dout),
     .resetN(link.resetN));
    // ----------------------------------------
    // Checking and driving
    // ----------------------------------------
    function automatic logic [23:0] rxOf(input logic [23:0] p, input logic [23:0] d, input logic [23:0] l);
        return p | d | ~l;
    endfunction : rxOf
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic check24(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : check24
    task automatic check1(input logic got, input logic exp);
        check24({23'h000000, got}, {23'h000000, exp});
    endtask : check1
    task automatic runHost(input logic m0, input logic [23:0] tx);
        int n;
        n = 0;
        txWord = tx;
        mode0Req = m0;
        frameReq = ~m0;
        @(negedge clk_sys);
        mode0Req = 1'b0;
        frameReq = 1'b0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 3000)
        begin
            bad_count++;
            final_report();
        end
        check1(frameDone, 1'b1);
        repeat (12) @(negedge clk_sys);
    endtask : runHost
    task automatic frame(input logic [23:0] tx, input logic cfg);
        padIn = 24'($urandom);
        repeat (6) @(negedge clk_sys);
        runHost(1'b0, tx);
        check24(rxWord, rxOf(padIn, dirExp, lvlExp));
        if (cfg)
            dirExp = tx;
        else
            lvlExp = tx;
        check1(dataMode, 1'b1);
        check24(padOe, dirExp | ~lvlExp);
        check24(padOut, dirExp & lvlExp);
    endtask : frame
    // Drives the second link by hand with a 48 ns link clock; din shows the inverse once released
    task automatic bang(input int n, input logic [23:0] w);
        linkB.csN = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            linkB.sclk = 1'b0;
            linkB.din = w[i];
            #24;
            linkB.sclk = 1'b1;
            #24;
        end
        linkB.csN = 1'b1;
        linkB.din = ~linkB.din;
        repeat (12) @(negedge clk_sys);
    endtask : bang
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'he94c6492));
        linkB.sclk = 1'b1;
        linkB.csN = 1'b1;
        linkB.din = 1'b1;
        linkB.resetN = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        check24(padOe, 24'h000000);
        check24(padOut, 24'h000000);
        check1(dataMode, 1'b0);
        check1(link.dout, 1'b1);
        linkB.resetN = 1'b1;
        repeat (12) @(negedge clk_sys);
        $display("test reset done");
        frame(24'($urandom), 1'b1);
        $display("test config done");
        for (int k = 0; k < 8; k++)
            frame(k == 0 ? 24'h000000 : (k == 1 ? 24'hffffff : 24'($urandom)), 1'b0);
        $display("test data done");
        resetReq = 1'b1;
        repeat (8) @(negedge clk_sys);
        check1(link.dout, 1'b1);
        check24(padOe, 24'h000000);
        resetReq = 1'b0;
        repeat (12) @(negedge clk_sys);
        check1(dataMode, 1'b0);
        dirExp = expander_pkg::DIR_RESET;
        lvlExp = expander_pkg::LEVEL_RESET;
        runHost(1'b1, 24'h000000);
        check1(dataMode, 1'b1);
        frame(24'h5a5a5a, 1'b0);
        $display("test mode0 done");
        bang(5, 24'hffffff);
        check1(dataModeB, 1'b0);
        bang(24, 24'hffffff);
        check1(dataModeB, 1'b1);
        bang(24, 24'h00ff0f);
        check24(padOeB, 24'hffffff);
        check24(padOutB, 24'h00ff0f);
        bang(7, 24'h000000);
        check24(padOutB, 24'h00ff0f);
        repeat (48)
        begin
            linkB.sclk = ~linkB.sclk;
            linkB.din = ~linkB.din;
            #24;
        end
        repeat (12) @(negedge clk_sys);
        check24(padOutB, 24'h00ff0f);
        $display("test refused done");
        final_report();
    end
endmodule : test_serial_io_expander_24bit
